//--- rtl/cprc_defs.vh
// constants for the control pin and reset configuration block
`ifndef CPRC_DEFS_VH
`define CPRC_DEFS_VH
// internal reset sequence length in cpu clocks
`define CPRC_RST_SEQ_CYCLES 16'h0400
`define CPRC_CNT_W 16
// register port offsets
`define CPRC_ADDR_CTRL 4'h0
`define CPRC_ADDR_STAT 4'h1
// control register fields
`define CPRC_CTRL_BDRST 0
`define CPRC_CTRL_BUS_ACTIVE_BITS_LO 1
`define CPRC_CTRL_BUS_ACTIVE_BITS_HI 5
`define CPRC_CTRL_RDYEN 6
`define CPRC_CTRL_RDYSYNC 7
`define CPRC_CTRL_WS_LO 8
`define CPRC_CTRL_WS_HI 11
`define CPRC_CTRL_WRMODE 12
// access kinds
`define CPRC_ACC_INT 2'h0
`define CPRC_ACC_XPER 2'h1
`define CPRC_ACC_EXT 2'h2
`endif

//--- rtl/cprc_ctrl.v
// control pin, reset sequencing and configuration latch logic
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "cprc_defs.vh"

module cprc_ctrl #(
  parameter [15:0] RST_SEQ_CYCLES = `CPRC_RST_SEQ_CYCLES
) (
  // clock and reset
  input wire clock,
  input wire reset,
  // reset pins
  input wire reset_in_n_i,
  output reg reset_in_n_o,
  output reg reset_in_n_oe,
  input wire reset_out_n_i,
  output reg reset_out_n_o,
  output reg reset_out_n_oe,
  input wire emulation_mode,
  // internal reset causes and instructions
  input wire software_reset_instr,
  input wire watchdog_overflow,
  input wire end_of_init_instr,
  input wire power_down_instr,
  // configuration pins
  input wire external_fetch_sel_n,
  input wire [15:0] config_port,
  input wire address_strobe_in,
  input wire read_strobe_n_in,
  // bus cycle requests from the controller
  input wire cycle_start,
  input wire [1:0] cycle_kind,
  input wire cycle_read,
  input wire [1:0] cycle_byte_en,
  input wire cycle_16bit,
  // bus pins
  input wire ready_n,
  output reg address_strobe_out,
  output reg read_strobe_n,
  output reg write_low_strobe_n,
  output reg write_high_strobe_n,
  output reg cycle_done,
  // trap and power down
  input wire nonmaskable_trap_in,
  output reg nmi_trap,
  output reg power_down_ok,
  // register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // latched configuration
  output reg internal_seq_active,
  output reg osc_watchdog_disable,
  output reg bootstrap_enable,
  output reg alt_boot,
  output reg fetch_internal,
  output reg [15:0] config_latched,
  output reg long_hw_reset_flag
);

  // ****************************************************************
  // states of the reset sequencer
  // ****************************************************************
  localparam [2:0] ST_SEQ = 3'h1; // internal reset sequence running
  localparam [2:0] ST_INIT = 3'h2; // running, before end of init
  localparam [2:0] ST_RUN = 3'h4; // normal operation

  reg [2:0] state_q; // sequencer state
  reg [15:0] cnt_q; // sequence counter
  reg bidir_reset_enable_q; // open-drain reset pin mode
  reg init_done_q; // end of init executed
  reg [4:0] bus_active_bits_q; // bus enables, one per window
  reg rdy_en_q; // ready control on
  reg rdy_sync_q; // synchronous ready evaluation
  reg [3:0] waitstates_q; // waitstates before ready is looked at
  reg wr_low_mode_q; // 1: low-byte write strobe mode
  reg nmi_q; // previous trap sample
  reg rdy_s_q; // first ready stage
  reg rdy_ss_q; // second ready stage
  reg busy_q; // external cycle in progress
  reg [3:0] ws_q; // waitstate counter
  reg pin_low_q; // pin reset level seen outside our own drive

  wire rst_pin_low; // pin pulled low by something external
  wire int_trigger; // any cause of an internal reset
  wire xbus; // cycle shows on external strobes
  wire rdy_now; // ready as chosen for evaluation

  // our own drive must not retrigger the sequence
  assign rst_pin_low = !reset_in_n_i && !reset_in_n_oe;
  assign int_trigger = software_reset_instr || watchdog_overflow ||
                       rst_pin_low;
  // sync mode adds the two-flop stage; async takes the pin level
  assign rdy_now = rdy_sync_q ? !rdy_ss_q : !ready_n;

  // ****************************************************************
  // decode whether an access reaches the external strobes
  // ****************************************************************
  function ext_visible;
    input [1:0] kind;
    input [4:0] bus_active_bits;
    begin
      case (kind)
        `CPRC_ACC_EXT: ext_visible = 1'b1;
        `CPRC_ACC_XPER: ext_visible = |bus_active_bits;
        default: ext_visible = 1'b0;
      endcase
    end
  endfunction

  assign xbus = cycle_start && ext_visible(cycle_kind, bus_active_bits_q);

  // ****************************************************************
  // reset sequencer
  // ****************************************************************
  // the count is shared by stretching and the pin drive window
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_q <= ST_SEQ;
      cnt_q <= 16'h0000;
      pin_low_q <= 1'b0;
    end
    else
    begin
      pin_low_q <= rst_pin_low;
      case (state_q)
        ST_SEQ:
        begin
          // a short pin pulse still runs the whole count
          if (cnt_q >= RST_SEQ_CYCLES - 16'h0001)
          begin
            state_q <= ST_INIT;
            cnt_q <= 16'h0000;
          end
          else
          begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        ST_INIT, ST_RUN:
        begin
          if (int_trigger)
          begin
            state_q <= ST_SEQ;
            cnt_q <= 16'h0000;
          end
          else if (end_of_init_instr)
          begin
            state_q <= ST_RUN;
          end
        end
        default:
        begin
          state_q <= ST_SEQ;
          cnt_q <= 16'h0000;
        end
      endcase
    end
  end

  // ****************************************************************
  // reset pins and configuration latch
  // ****************************************************************
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      reset_in_n_o <= 1'b0;
      reset_in_n_oe <= 1'b0;
      reset_out_n_o <= 1'b0;
      reset_out_n_oe <= 1'b1;
      internal_seq_active <= 1'b1;
      osc_watchdog_disable <= 1'b0;
      bootstrap_enable <= 1'b0;
      alt_boot <= 1'b0;
      fetch_internal <= 1'b0;
      config_latched <= 16'h0000;
      long_hw_reset_flag <= 1'b0;
    end
    else
    begin
      reset_in_n_o <= 1'b0;
      internal_seq_active <= (state_q == ST_SEQ);
      // drive the pin only while bidirectional and in sequence
      reset_in_n_oe <= bidir_reset_enable_q && (state_q == ST_SEQ);
      // low from sequence start until end of init
      reset_out_n_o <= (state_q == ST_RUN) ||
                       ((state_q == ST_INIT) && end_of_init_instr);
      reset_out_n_oe <= !emulation_mode;
      if (state_q != ST_SEQ && int_trigger)
      begin
        // bidirectional mode always reports a long hardware reset
        long_hw_reset_flag <= bidir_reset_enable_q || pin_low_q;
      end
      if (state_q == ST_SEQ && cnt_q >= RST_SEQ_CYCLES - 16'h0001)
      begin
        fetch_internal <= external_fetch_sel_n;
        config_latched <= config_port;
        if (external_fetch_sel_n)
        begin
          alt_boot <= address_strobe_in;
          // pin and config port both can call the loader
          bootstrap_enable <= !read_strobe_n_in || !config_port[4];
        end
        else
        begin
          osc_watchdog_disable <= !read_strobe_n_in;
          bootstrap_enable <= !config_port[4];
          alt_boot <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  // the bidir bit clears on every reset sequence and locks at init
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      bidir_reset_enable_q <= 1'b0;
      init_done_q <= 1'b0;
      bus_active_bits_q <= 5'h00;
      rdy_en_q <= 1'b0;
      rdy_sync_q <= 1'b0;
      waitstates_q <= 4'h0;
      wr_low_mode_q <= 1'b0;
    end
    else if (state_q == ST_SEQ)
    begin
      // held to the last count so the pin drive spans the sequence
      if (cnt_q >= RST_SEQ_CYCLES - 16'h0001)
      begin
        bidir_reset_enable_q <= 1'b0;
      end
      init_done_q <= 1'b0;
    end
    else
    begin
      if (end_of_init_instr)
      begin
        init_done_q <= 1'b1;
      end
      if (reg_wr && reg_addr == `CPRC_ADDR_CTRL)
      begin
        if (!init_done_q)
        begin
          bidir_reset_enable_q <= reg_wdata[`CPRC_CTRL_BDRST];
        end
        bus_active_bits_q <=
          reg_wdata[`CPRC_CTRL_BUS_ACTIVE_BITS_HI:`CPRC_CTRL_BUS_ACTIVE_BITS_LO];
        rdy_en_q <= reg_wdata[`CPRC_CTRL_RDYEN];
        rdy_sync_q <= reg_wdata[`CPRC_CTRL_RDYSYNC];
        waitstates_q <= reg_wdata[`CPRC_CTRL_WS_HI:`CPRC_CTRL_WS_LO];
        wr_low_mode_q <= reg_wdata[`CPRC_CTRL_WRMODE];
      end
    end
  end

  // ****************************************************************
  // register read port, data one cycle after the strobe
  // ****************************************************************
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `CPRC_ADDR_CTRL: reg_rdata <= {3'h0, wr_low_mode_q, waitstates_q,
          rdy_sync_q, rdy_en_q, bus_active_bits_q, bidir_reset_enable_q};
        `CPRC_ADDR_STAT: reg_rdata <= {8'h00, init_done_q, long_hw_reset_flag,
          fetch_internal, alt_boot, bootstrap_enable, osc_watchdog_disable,
          busy_q, internal_seq_active};
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
    begin
      reg_rdata <= 16'h0000;
    end
  end

  // ****************************************************************
  // bus strobes and ready
  // ****************************************************************
  // one cycle address strobe, command from the same edge until ready
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      address_strobe_out <= 1'b0;
      read_strobe_n <= 1'b1;
      write_low_strobe_n <= 1'b1;
      write_high_strobe_n <= 1'b1;
      cycle_done <= 1'b0;
      busy_q <= 1'b0;
      ws_q <= 4'h0;
      rdy_s_q <= 1'b1;
      rdy_ss_q <= 1'b1;
    end
    else
    begin
      rdy_s_q <= ready_n;
      rdy_ss_q <= rdy_s_q;
      cycle_done <= 1'b0;
      address_strobe_out <= 1'b0;
      if (state_q == ST_SEQ)
      begin
        // strobes parked inactive while in reset
        busy_q <= 1'b0;
        read_strobe_n <= 1'b1;
        write_low_strobe_n <= 1'b1;
        write_high_strobe_n <= 1'b1;
        address_strobe_out <= 1'b0;
      end
      else if (!busy_q && xbus)
      begin
        address_strobe_out <= 1'b1;
        busy_q <= 1'b1;
        ws_q <= waitstates_q;
        // peripheral cycles never show read or write strobes
        if (cycle_kind == `CPRC_ACC_EXT)
        begin
          read_strobe_n <= !cycle_read;
          if (!cycle_read)
          begin
            if (wr_low_mode_q && cycle_16bit)
            begin
              write_low_strobe_n <= !cycle_byte_en[0];
              write_high_strobe_n <= !cycle_byte_en[1];
            end
            else
            begin
              write_low_strobe_n <= 1'b0;
            end
          end
        end
      end
      else if (!busy_q && cycle_start)
      begin
        cycle_done <= 1'b1;
      end
      else if (busy_q)
      begin
        if (ws_q != 4'h0)
        begin
          ws_q <= ws_q - 4'h1;
        end
        else if (!rdy_en_q || rdy_now)
        begin
          busy_q <= 1'b0;
          cycle_done <= 1'b1;
          read_strobe_n <= 1'b1;
          write_low_strobe_n <= 1'b1;
          write_high_strobe_n <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // trap input edge detection
  // ****************************************************************
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      nmi_q <= 1'b1;
      nmi_trap <= 1'b0;
      power_down_ok <= 1'b0;
    end
    else
    begin
      nmi_q <= nonmaskable_trap_in;
      nmi_trap <= nmi_q && !nonmaskable_trap_in;
      power_down_ok <= power_down_instr && !nonmaskable_trap_in;
    end
  end

endmodule // cprc_ctrl
`default_nettype wire

//--- dv/cprc_monitor.sv
// assertion checker bound to the control pin and reset block
`timescale 1ns/1ns
`default_nettype none
module cprc_monitor #(
  parameter [15:0] RST_SEQ_CYCLES = 16'h0400
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // stimulus seen by the block
  input wire logic emulation_mode,
  input wire logic end_of_init_instr,
  input wire logic power_down_instr,
  input wire logic nonmaskable_trap_in,
  input wire logic cycle_start,
  input wire logic [1:0] cycle_kind,
  // outputs of the block
  input wire logic reset_in_n_o,
  input wire logic reset_in_n_oe,
  input wire logic reset_out_n_o,
  input wire logic reset_out_n_oe,
  input wire logic address_strobe_out,
  input wire logic read_strobe_n,
  input wire logic write_low_strobe_n,
  input wire logic nmi_trap,
  input wire logic power_down_ok,
  input wire logic internal_seq_active
);
  // ********************
  // helper logic
  // ********************
  logic [16:0] seq_q; // cycles spent in the running sequence
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // counts up inside a sequence, back to zero between sequences
  always @(posedge clock or posedge reset)
    if (reset)
      seq_q <= 17'h00000;
    else
      seq_q <= internal_seq_active ? seq_q + 17'h00001 : 17'h00000;
  // ********************
  // assertions
  // ********************
  chk_ale_seq: assert property (internal_seq_active |->
    !address_strobe_out)
    else $error("address strobe inside reset sequence");
  chk_cmd_seq: assert property (internal_seq_active |->
    read_strobe_n && write_low_strobe_n)
    else $error("command strobe inside reset sequence");
  chk_ale_cause: assert property (address_strobe_out |->
    $past(cycle_start) && $past(cycle_kind) != 2'h0)
    else $error("address strobe without visible cycle");
  chk_ale_pulse: assert property (address_strobe_out |=>
    !address_strobe_out)
    else $error("address strobe longer than one cycle");
  chk_xper_cmd: assert property (address_strobe_out &&
    $past(cycle_kind) == 2'h1 |-> read_strobe_n && write_low_strobe_n)
    else $error("command strobe on peripheral cycle");
  chk_pd_gate: assert property (power_down_ok |->
    $past(power_down_instr) && !$past(nonmaskable_trap_in))
    else $error("power down accepted without trap input low");
  chk_nmi_pulse: assert property (nmi_trap |=> !nmi_trap)
    else $error("trap pulse longer than one cycle");
  chk_out_init: assert property ($rose(reset_out_n_o) |->
    $past(end_of_init_instr) || $past(end_of_init_instr, 2))
    else $error("reset output released without init");
  chk_drive_seq: assert property (reset_in_n_oe |-> !reset_in_n_o &&
    (internal_seq_active || $past(internal_seq_active)))
    else $error("reset pin driven outside sequence");
  chk_emu_in: assert property (emulation_mode && $past(emulation_mode)
    |-> !reset_out_n_oe)
    else $error("reset output driven in emulation");
  chk_seq_len: assert property (
    seq_q <= {1'b0, RST_SEQ_CYCLES} + 17'h00002)
    else $error("reset sequence too long");
  // main scenarios reached
  cover property (address_strobe_out && $past(cycle_kind) == 2'h1);
  cover property (reset_in_n_oe);
  cover property (nmi_trap);
  cover property (power_down_ok);
endmodule // cprc_monitor
bind cprc_ctrl cprc_monitor #(.RST_SEQ_CYCLES(RST_SEQ_CYCLES)) u_mon (.*);
`default_nettype wire

//--- dv/cprc_far_model.sv
// far-side model: external reset circuitry and a ready-answering memory
`timescale 1ns/1ns
`default_nettype none
module cprc_far_model (
  // clock and bench controls
  input wire logic clock,
  input wire logic ext_rst_low,
  input wire logic [1:0] ready_delay,
  // pins driven by the block
  input wire logic reset_in_n_o,
  input wire logic reset_in_n_oe,
  input wire logic read_strobe_n,
  input wire logic write_low_strobe_n,
  input wire logic write_high_strobe_n,
  // pins seen by the block
  output logic reset_in_n_i,
  output logic ready_n
);
  logic [2:0] wait_q = 3'h0; // cycles since a command strobe went low
  wire idle = read_strobe_n && write_low_strobe_n && write_high_strobe_n;
  // open drain: each side only pulls low, the pull-up wins otherwise
  assign reset_in_n_i = !ext_rst_low &&
                        !(reset_in_n_oe && !reset_in_n_o);
  always @(posedge clock)
    wait_q <= idle ? 3'h0 : wait_q + 3'h1;
  // answer after the chosen delay; the pull-up holds it high when idle
  assign ready_n = idle || wait_q < {1'b0, ready_delay};
endmodule // cprc_far_model
`default_nettype wire

//--- dv/cprc_ctrl_bench.sv
// self-checking bench for the control pin and reset block
`timescale 1ns/1ns
`default_nettype none
module cprc_ctrl_bench;
  localparam [15:0] SEQ = 16'h0008; // short sequence keeps the run brief
  logic clock, reset, emulation_mode, software_reset_instr, watchdog_overflow;
  logic end_of_init_instr, power_down_instr, external_fetch_sel_n, v;
  logic address_strobe_in, read_strobe_n_in, cycle_start, cycle_read;
  logic cycle_16bit, nonmaskable_trap_in, reg_wr, reg_rd, ext_rst_low;
  logic [15:0] config_port, reg_wdata, n, d;
  logic [1:0] cycle_kind, cycle_byte_en, ready_delay, k;
  logic [3:0] reg_addr;
  logic [31:0] r;
  wire logic reset_in_n_i, reset_in_n_o, reset_in_n_oe, reset_out_n_i;
  wire logic reset_out_n_o, reset_out_n_oe, ready_n, address_strobe_out;
  wire logic read_strobe_n, write_low_strobe_n, write_high_strobe_n;
  wire logic cycle_done, nmi_trap, power_down_ok, internal_seq_active;
  wire logic osc_watchdog_disable, bootstrap_enable, alt_boot;
  wire logic fetch_internal, long_hw_reset_flag;
  wire logic [15:0] reg_rdata, config_latched;
  int miscompares, compares;
  // outside circuitry keeps the reset output pin inactive in emulation
  assign reset_out_n_i = reset_out_n_oe ? reset_out_n_o : 1'b1;
  cprc_ctrl #(.RST_SEQ_CYCLES(SEQ)) u_dut (.*);
  cprc_far_model u_far (.*);
  // ********************
  // tasks
  // ********************
  task automatic chk(input string w, input logic [15:0] e,
    input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic conclude;
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // bounded wait: 0 sequence over, 1 cycle done, 2 reset pin driven
  task automatic await(input int s);
    n = 16'h0000;
    while ((s == 0 && internal_seq_active !== 1'b0) ||
      (s == 1 && cycle_done !== 1'b1) || (s == 2 && reset_in_n_oe !== 1'b1))
    begin
      @(posedge clock);
      #1 n = n + 16'h0001;
      if (n > 16'h00C8)
      begin
        miscompares++;
        conclude();
      end
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] x);
    @(posedge clock);
    {reg_addr, reg_wdata, reg_wr} <= {a, x, 1'b1};
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // ********************
  // clock and sequence
  // ********************
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    {reset, emulation_mode, software_reset_instr, watchdog_overflow} = 4'hF;
    {end_of_init_instr, power_down_instr, cycle_start, cycle_read} = 4'h0;
    // trap pin idles high, so no false falling edge after reset
    {cycle_16bit, nonmaskable_trap_in, reg_wr, reg_rd, ext_rst_low} = 5'h08;
    {emulation_mode, software_reset_instr, watchdog_overflow} = 3'h0;
    {config_port, reg_wdata, cycle_kind, cycle_byte_en} = 36'h0;
    {ready_delay, reg_addr, external_fetch_sel_n} = 7'h01;
    {address_strobe_in, read_strobe_n_in} = 2'h1;
    void'($urandom(32'h3B8F));
    // configuration latched over hardware resets
    for (int i = 0; i < 4; i++)
    begin
      r = $urandom;
      @(posedge clock);
      reset <= 1'b1;
      external_fetch_sel_n <= i[0];
      {read_strobe_n_in, address_strobe_in, config_port} <= r[17:0];
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      #1 chk("ale", 0, address_strobe_out);
      chk("rds", 1, read_strobe_n);
      chk("wrl", 1, write_low_strobe_n);
      repeat (2) @(posedge clock);
      await(0);
      chk("fetch", i[0], fetch_internal);
      chk("cfg", r[15:0], config_latched);
      chk("owd", !i[0] && !r[17], osc_watchdog_disable);
      if (i[0]) chk("boot", !r[17] || !r[4], bootstrap_enable);
      if (i[0]) chk("alt", r[16], alt_boot);
      chk("out", 0, reset_out_n_o);
      rd(4'h0);
      chk("ctl", 0, d);
      rd(4'hF);
      chk("unmapped", 0, d);
    end
    // bus cycles of every kind and mode, waitstate counts 0 to 3
    for (int i = 0; i < 24; i++)
    begin
      r = $urandom;
      k = (r[1:0] == 2'h3) ? 2'h2 : r[1:0];
      v = k == 2'h2 || (k == 2'h1 && r[9]);
      ready_delay <= r[3:2];
      wr(4'h0, {3'h0, r[4], 2'h0, r[6:5], r[7], r[8] && k == 2'h2, 4'h0,
        r[9], 1'b0});
      @(posedge clock);
      {cycle_start, cycle_kind, cycle_read} <= {1'b1, k, r[10]};
      cycle_16bit <= r[13]; // both write strobe modes are reached
      cycle_byte_en <= r[12:11] | {1'b0, r[12:11] == 2'h0};
      @(posedge clock);
      cycle_start <= 1'b0;
      #1 chk("ale", v, address_strobe_out);
      chk("rds", !(k == 2'h2 && r[10]), read_strobe_n);
      chk("wrl", (k == 2'h2 && !r[10]) ? r[4] && r[13] && !cycle_byte_en[0]
        : 1'b1, write_low_strobe_n);
      if (r[4]) chk("wrh", !(k == 2'h2 && !r[10] && r[13] && cycle_byte_en[1]),
        write_high_strobe_n);
      await(1);
      if (r[8] && k == 2'h2) chk("wsr", 1, n > r[6:5]);
      else chk("len", v ? {14'h0, r[6:5]} + 16'h0001 : 16'h0000, n);
    end
    // power down gated by the trap input, then a falling trap edge
    for (int t = 0; t < 2; t++)
    begin
      @(posedge clock);
      nonmaskable_trap_in <= t[0];
      @(posedge clock);
      power_down_instr <= 1'b1;
      @(posedge clock);
      power_down_instr <= 1'b0;
      #1 chk("pdn", !t[0], power_down_ok);
    end
    @(posedge clock);
    nonmaskable_trap_in <= 1'b0;
    n = 16'h0000;
    repeat (6)
    begin
      @(posedge clock);
      #1 n = n + nmi_trap;
    end
    chk("nmi", 1, n);
    // bidirectional reset by pin pulse, software and watchdog
    for (int t = 0; t < 3; t++)
    begin
      wr(4'h0, 16'h0001);
      @(posedge clock);
      end_of_init_instr <= 1'b1;
      @(posedge clock);
      end_of_init_instr <= 1'b0;
      @(posedge clock);
      #1 chk("out", 1, reset_out_n_o);
      wr(4'h0, 16'h0000);
      rd(4'h0);
      chk("lock", 1, d[0]);
      @(posedge clock);
      {ext_rst_low, software_reset_instr, watchdog_overflow} <= 3'h4 >> t;
      @(posedge clock);
      {ext_rst_low, software_reset_instr, watchdog_overflow} <= 3'h0;
      await(2);
      chk("out", 0, reset_out_n_o);
      // the pin stays driven for the whole stretched sequence
      n = 16'h0001;
      repeat (SEQ + 16'h0002)
      begin
        @(posedge clock);
        #1 n = n + reset_in_n_oe;
      end
      chk("drvlen", SEQ, n);
      await(0);
      @(posedge clock);
      #1 chk("drive", 0, reset_in_n_oe);
      chk("long", 1, long_hw_reset_flag);
      rd(4'h0);
      chk("clr", 0, d[0]);
    end
    @(posedge clock);
    emulation_mode <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk("emu", 0, reset_out_n_oe);
    conclude();
  end
endmodule // cprc_ctrl_bench
`default_nettype wire
